/* hdl/tpr_regs.svh */
// Register offsets, field positions, reset values and template constants
// for the per-channel pulse template access block.
// Assumes it is included by bare name in every file that needs these values.
`ifndef TPR_REGS_SVH
`define TPR_REGS_SVH

// Register indexes within one channel; the byte address is four times the index.
`define TPR_GAIN_IDX 8'h04
`define TPR_CTRL_IDX 8'h05
`define TPR_DATA_IDX 8'h06
// Index stride between two channels.
`define TPR_CH_STRIDE 8'h20

// Field positions.
`define TPR_TRIG_BIT 7
`define TPR_DIR_BIT 6
`define TPR_UI_MSB 5
`define TPR_UI_LSB 4
`define TPR_POS_MSB 3
`define TPR_POS_LSB 0
`define TPR_GAIN_MSB 5
`define TPR_VALUE_MSB 6

// Reset values.
`define TPR_GAIN_RST 6'h21
`define TPR_CTRL_RST 7'h00
`define TPR_VALUE_RST 7'h00

// Template selection codes whose top two bits mark the user template.
`define TPR_USER_SEL 2'h3
`define TPR_SEL_E1_75 4'h0
`define TPR_SEL_E1_120 4'h1
`define TPR_SEL_SH_FIRST 4'h2
`define TPR_SEL_LH_0DB 4'h8
`define TPR_SEL_LH_7DB5 4'h9
`define TPR_SEL_LH_15DB 4'ha
`define TPR_SEL_LH_22DB5 4'hb

// Nominal gain factor per template family.
`define TPR_NOM_T1 6'h36
`define TPR_NOM_7DB5 6'h11
`define TPR_NOM_15DB 6'h08
`define TPR_NOM_22DB5 6'h04
`define TPR_NOM_E1 6'h21

// Amplitude change per gain step, in quarter percent.
`define TPR_STEP_T1 7'h08
`define TPR_STEP_7DB5 7'h19
`define TPR_STEP_15DB 7'h32
`define TPR_STEP_22DB5 7'h64
`define TPR_STEP_E1 7'h0c

`endif

/* hdl/tpr_pkg.sv */
// Types shared by the pulse template access block.
// Assumes nothing of its surroundings.
package tpr_pkg;

  // Sequencer states of the indirect template access.
  typedef enum logic [1:0] {
    st_idle = 2'b00,
    st_issue = 2'b01,
    st_finish = 2'b10
  } tpr_state_t;

endpackage : tpr_pkg

/* hdl/tpr_template_ram.sv */
// Pulse template memory with one read/write port and one read-only port.
// Assumes a single clock; contents are not cleared by reset.
`timescale 1ns/100ps

module tpr_template_ram #(
  parameter int ADDR_W = 9,
  parameter int DATA_W = 7
) (
  input wire logic pclk, // Clock.
  input wire logic presetn, // Asynchronous reset, active low.
  input wire logic a_en, // Port A access strobe.
  input wire logic a_we, // Port A writes when high.
  input wire logic [ADDR_W-1:0] a_addr, // Port A word address.
  input wire logic [DATA_W-1:0] a_wdata, // Port A write data.
  output logic [DATA_W-1:0] a_rdata, // Port A read data, one cycle after the strobe.
  input wire logic [ADDR_W-1:0] b_addr, // Port B word address.
  output logic [DATA_W-1:0] b_rdata // Port B read data, one cycle later.
);

  logic [DATA_W-1:0] mem [2**ADDR_W];

  // Stores the sample amplitude on a port A write.
  always_ff @(posedge pclk) begin
    if (a_en && a_we) begin
      mem[a_addr] <= a_wdata;
    end
  end

  // Registered read of port A.
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      a_rdata <= '0;
    end else if (a_en && !a_we) begin
      a_rdata <= mem[a_addr];
    end
  end

  // Registered read of port B for the waveform shaper.
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      b_rdata <= '0;
    end else begin
      b_rdata <= mem[b_addr];
    end
  end

endmodule : tpr_template_ram

/* hdl/tpr_pulse_template_access.sv */
// Per-channel gain and indirect pulse template access registers on APB.
// Assumes an APB master on pclk and template selections from logic on pclk.
//
// The APB slave port was left to the implementer.
`timescale 1ns/100ps
`include "tpr_regs.svh"

module tpr_pulse_template_access #(
  parameter int CHANNELS = 8,
  parameter int ADDR_W = 10
) (
  input wire logic pclk, // APB clock, 40 MHz.
  input wire logic presetn, // Asynchronous reset, active low.
  input wire logic psel, // APB select.
  input wire logic penable, // APB enable.
  input wire logic pwrite, // APB direction, high for write.
  input wire logic [ADDR_W-1:0] paddr, // APB byte address.
  input wire logic [31:0] pwdata, // APB write data.
  output logic [31:0] prdata, // APB read data.
  output logic pready, // APB ready.
  output logic pslverr, // APB error on an unmapped address.
  input wire logic [4*CHANNELS-1:0] template_selection, // Template code per channel.
  input wire logic [2:0] shaper_channel, // Shaper read channel.
  input wire logic [1:0] shaper_ui, // Shaper read unit interval.
  input wire logic [3:0] shaper_position, // Shaper read sample.
  output logic [6:0] shaper_sample, // Sample amplitude, zero outside user mode.
  output logic [CHANNELS-1:0] user_mode, // Channel uses the user template.
  output logic [6*CHANNELS-1:0] applied_gain, // Gain factor in force per channel.
  output logic [7*CHANNELS-1:0] gain_step // Amplitude per gain step, quarter percent.
);

  ////////////////////////////////////////////////////////////////////////////
  // Decoding helpers.

  // Returns 1 gain, 2 control, 3 sample value, 0 unmapped.
  function automatic logic [1:0] reg_select(input logic [ADDR_W-1:0] addr);
    logic [7:0] idx;
    idx = addr[9:2] & (`TPR_CH_STRIDE - 8'h01);
    reg_select = 2'h0;
    if (addr[1:0] == 2'h0) begin
      if (idx == `TPR_GAIN_IDX) reg_select = 2'h1;
      else if (idx == `TPR_CTRL_IDX) reg_select = 2'h2;
      else if (idx == `TPR_DATA_IDX) reg_select = 2'h3;
    end
  endfunction : reg_select

  // Nominal gain factor of a built-in template.
  function automatic logic [5:0] nominal_gain(input logic [3:0] sel);
    if (sel == `TPR_SEL_E1_75 || sel == `TPR_SEL_E1_120) nominal_gain = `TPR_NOM_E1;
    else if (sel == `TPR_SEL_LH_7DB5) nominal_gain = `TPR_NOM_7DB5;
    else if (sel == `TPR_SEL_LH_15DB) nominal_gain = `TPR_NOM_15DB;
    else if (sel == `TPR_SEL_LH_22DB5) nominal_gain = `TPR_NOM_22DB5;
    else nominal_gain = `TPR_NOM_T1;
  endfunction : nominal_gain

  // Amplitude change of one gain step for a template.
  function automatic logic [6:0] step_size(input logic [3:0] sel);
    if (sel == `TPR_SEL_E1_75 || sel == `TPR_SEL_E1_120) step_size = `TPR_STEP_E1;
    else if (sel == `TPR_SEL_LH_7DB5) step_size = `TPR_STEP_7DB5;
    else if (sel == `TPR_SEL_LH_15DB) step_size = `TPR_STEP_15DB;
    else if (sel == `TPR_SEL_LH_22DB5) step_size = `TPR_STEP_22DB5;
    else step_size = `TPR_STEP_T1;
  endfunction : step_size

  // True when a template code selects the user-programmable waveform.
  function automatic logic is_user(input logic [3:0] sel);
    is_user = (sel[3:2] == `TPR_USER_SEL);
  endfunction : is_user

  // Lowest channel with a pending access.
  function automatic logic [2:0] first_pending(input logic [CHANNELS-1:0] pend);
    first_pending = 3'h0;
    for (int i = CHANNELS - 1; i >= 0; i--) begin
      if (pend[i]) first_pending = 3'(i);
    end
  endfunction : first_pending

  ////////////////////////////////////////////////////////////////////////////
  // APB slave.

  logic [5:0] gain [CHANNELS];
  logic [6:0] access_cfg [CHANNELS];
  logic [6:0] sample_value [CHANNELS];
  logic [CHANNELS-1:0] pending;
  logic [1:0] sel_now;
  logic [2:0] ch_now;
  logic wr_done;
  logic [CHANNELS-1:0] trig_set;

  assign sel_now = reg_select(paddr);
  assign ch_now = paddr[9:7];
  // A write takes effect at the edge where the access phase completes.
  assign wr_done = psel && penable && pready && pwrite && (sel_now != 2'h0);

  // One wait state; read data and error are captured with ready.
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      pready <= 1'b0;
      pslverr <= 1'b0;
      prdata <= 32'h0000_0000;
    end else if (psel && penable && !pready) begin
      pready <= 1'b1;
      pslverr <= (sel_now == 2'h0);
      unique case (sel_now)
        2'h1: prdata <= {26'h000_0000, gain[ch_now]};
        2'h2: prdata <= {24'h00_0000, pending[ch_now], access_cfg[ch_now]};
        2'h3: prdata <= {25'h000_0000, sample_value[ch_now]};
        2'h0: prdata <= 32'h0000_0000;
      endcase
    end else begin
      pready <= 1'b0;
      pslverr <= 1'b0;
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // Access sequencer.

  tpr_pkg::tpr_state_t state;
  logic [2:0] cur;
  logic ram_a_en;
  logic ram_a_we;
  logic [8:0] ram_a_addr;
  logic [6:0] ram_a_wdata;
  logic [6:0] ram_a_rdata;
  logic [6:0] ram_b_rdata;
  logic is_read;

  // Picks one pending channel, accesses memory, then retires the trigger.
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      state <= tpr_pkg::st_idle;
      cur <= 3'h0;
    end else begin
      unique case (state)
        tpr_pkg::st_idle: begin
          if (pending != '0) begin
            cur <= first_pending(pending);
            state <= tpr_pkg::st_issue;
          end
        end
        tpr_pkg::st_issue: state <= tpr_pkg::st_finish;
        tpr_pkg::st_finish: state <= tpr_pkg::st_idle;
        default: state <= tpr_pkg::st_idle;
      endcase
    end
  end

  assign is_read = access_cfg[cur][`TPR_DIR_BIT];
  assign ram_a_en = (state == tpr_pkg::st_issue);
  assign ram_a_we = !is_read;
  assign ram_a_addr = {cur, access_cfg[cur][`TPR_UI_MSB:`TPR_UI_LSB],
                       access_cfg[cur][`TPR_POS_MSB:`TPR_POS_LSB]};
  assign ram_a_wdata = sample_value[cur];

  ////////////////////////////////////////////////////////////////////////////
  // Per-channel registers and outputs.

  genvar g;
  generate
    for (g = 0; g < CHANNELS; g++) begin : g_ch
      logic wr_here;
      logic retire;
      assign wr_here = wr_done && (ch_now == 3'(g));
      assign retire = (state == tpr_pkg::st_finish) && (cur == 3'(g));
      assign trig_set[g] = wr_here && (sel_now == 2'h2) && pwdata[`TPR_TRIG_BIT];

      // Gain factor register.
      always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
          gain[g] <= `TPR_GAIN_RST;
        end else if (wr_here && sel_now == 2'h1) begin
          gain[g] <= pwdata[`TPR_GAIN_MSB:0];
        end
      end

      // Direction and address fields of the access control register.
      always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
          access_cfg[g] <= `TPR_CTRL_RST;
        end else if (wr_here && sel_now == 2'h2) begin
          access_cfg[g] <= pwdata[`TPR_DIR_BIT:0];
        end
      end

      // Trigger bit: a new trigger wins over the retiring clear.
      always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
          pending[g] <= 1'b0;
        end else begin
          pending[g] <= (pending[g] && !retire) || trig_set[g];
        end
      end

      // Sample value: a finished read wins over a software write.
      always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
          sample_value[g] <= `TPR_VALUE_RST;
        end else if (retire && is_read) begin
          sample_value[g] <= ram_a_rdata;
        end else if (wr_here && sel_now == 2'h3) begin
          sample_value[g] <= pwdata[`TPR_VALUE_MSB:0];
        end
      end

      // Gain in force: the register only in user mode, else the template nominal.
      always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
          user_mode[g] <= 1'b0;
          applied_gain[6*g +: 6] <= `TPR_NOM_E1;
          gain_step[7*g +: 7] <= `TPR_STEP_E1;
        end else begin
          user_mode[g] <= is_user(template_selection[4*g +: 4]);
          if (is_user(template_selection[4*g +: 4])) begin
            applied_gain[6*g +: 6] <= gain[g];
            gain_step[7*g +: 7] <= `TPR_STEP_E1;
          end else begin
            applied_gain[6*g +: 6] <= nominal_gain(template_selection[4*g +: 4]);
            gain_step[7*g +: 7] <= step_size(template_selection[4*g +: 4]);
          end
        end
      end
    end
  endgenerate

  ////////////////////////////////////////////////////////////////////////////
  // Template memory and shaper read path.

  logic [2:0] shaper_ch_q;

  tpr_template_ram #(
    .ADDR_W(9),
    .DATA_W(7)
  ) u_ram (
    .pclk(pclk),
    .presetn(presetn),
    .a_en(ram_a_en),
    .a_we(ram_a_we),
    .a_addr(ram_a_addr),
    .a_wdata(ram_a_wdata),
    .a_rdata(ram_a_rdata),
    .b_addr({shaper_channel, shaper_ui, shaper_position}),
    .b_rdata(ram_b_rdata)
  );

  // Shaper sample is blanked unless its channel runs the user template.
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      shaper_ch_q <= 3'h0;
      shaper_sample <= 7'h00;
    end else begin
      shaper_ch_q <= shaper_channel;
      shaper_sample <= user_mode[shaper_ch_q] ? ram_b_rdata : 7'h00;
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // Assertions.

  sequence s_trig_ch0;
    wr_done && ch_now == 3'h0 && sel_now == 2'h2 && pwdata[`TPR_TRIG_BIT];
  endsequence

  sequence s_access;
    state == tpr_pkg::st_issue ##1 state == tpr_pkg::st_finish;
  endsequence

  // Register bus: one wait state, a one-cycle ready and an error for unmapped places.
  a_ready_wait: assert property (@(posedge pclk) disable iff (!presetn)
    psel && !penable |=> !pready)
    else $error("ready raised without a wait state");
  a_ready_pulse: assert property (@(posedge pclk) disable iff (!presetn)
    pready |=> !pready)
    else $error("ready held for more than one cycle");
  a_unmapped_err: assert property (@(posedge pclk) disable iff (!presetn)
    psel && penable && !pready && sel_now == 2'h0 |=> pready && pslverr && prdata == 32'h0000_0000)
    else $error("unmapped access answered without an error");

  // Gain factor register and the gain in force per template.
  a_gain_write: assert property (@(posedge pclk) disable iff (!presetn)
    wr_done && sel_now == 2'h1 |=> gain[$past(ch_now)] == $past(pwdata[5:0]))
    else $error("gain factor write not stored");
  a_nominal_t1: assert property (@(posedge pclk) disable iff (!presetn)
    template_selection[3:0] == `TPR_SEL_LH_0DB |=> applied_gain[5:0] == 6'h36 && gain_step[6:0] == 7'h08)
    else $error("wrong nominal gain for 0 dB template");
  a_nominal_7db5: assert property (@(posedge pclk) disable iff (!presetn)
    template_selection[3:0] == `TPR_SEL_LH_7DB5 |=> applied_gain[5:0] == 6'h11 && gain_step[6:0] == 7'h19)
    else $error("wrong nominal gain for -7.5 dB template");
  a_nominal_15db: assert property (@(posedge pclk) disable iff (!presetn)
    template_selection[3:0] == `TPR_SEL_LH_15DB |=> applied_gain[5:0] == 6'h08 && gain_step[6:0] == 7'h32)
    else $error("wrong nominal gain for -15 dB template");
  a_nominal_22db5: assert property (@(posedge pclk) disable iff (!presetn)
    template_selection[3:0] == `TPR_SEL_LH_22DB5 |=> applied_gain[5:0] == 6'h04 && gain_step[6:0] == 7'h64)
    else $error("wrong nominal gain for -22.5 dB template");
  a_nominal_e1: assert property (@(posedge pclk) disable iff (!presetn)
    template_selection[3:1] == 3'h0 |=> applied_gain[5:0] == 6'h21 && gain_step[6:0] == 7'h0c)
    else $error("wrong nominal gain for E1 template");

  // Indirect access: trigger, address, direction, data and completion.
  a_trigger_start: assert property (@(posedge pclk) disable iff (!presetn)
    s_trig_ch0 |-> ##[1:24] (ram_a_en && ram_a_addr[8:6] == 3'h0))
    else $error("triggered access never reached memory");
  a_trigger_set: assert property (@(posedge pclk) disable iff (!presetn)
    s_trig_ch0 |=> pending[0])
    else $error("trigger bit not set by a control write");
  a_access_dir: assert property (@(posedge pclk) disable iff (!presetn)
    ram_a_en |-> ram_a_we == !access_cfg[cur][6])
    else $error("memory direction differs from direction bit");
  a_access_addr: assert property (@(posedge pclk) disable iff (!presetn)
    ram_a_en |-> ram_a_addr[5:0] == access_cfg[cur][5:0] && ram_a_addr[8:6] == cur)
    else $error("memory address differs from selected sample");
  a_write_data: assert property (@(posedge pclk) disable iff (!presetn)
    ram_a_en && ram_a_we |=> u_ram.mem[$past(ram_a_addr)] == $past(sample_value[cur]))
    else $error("written amplitude not stored in template memory");
  a_read_result: assert property (@(posedge pclk) disable iff (!presetn)
    s_access ##0 is_read |=> sample_value[$past(cur)] == $past(ram_a_rdata))
    else $error("read amplitude not placed in sample value");

  // User template gating of gain and shaper samples, and clearing of the trigger after an access.
  a_user_gain: assert property (@(posedge pclk) disable iff (!presetn)
    template_selection[3:2] == `TPR_USER_SEL |=> user_mode[0] && applied_gain[5:0] == $past(gain[0]))
    else $error("user template does not apply the gain register");
  a_user_gate: assert property (@(posedge pclk) disable iff (!presetn)
    !user_mode[shaper_ch_q] |=> shaper_sample == 7'h00)
    else $error("template shaped pulse outside user mode");
  a_trigger_clear: assert property (@(posedge pclk) disable iff (!presetn)
    s_access ##0 !trig_set[cur] |=> state == tpr_pkg::st_idle && !pending[cur])
    else $error("trigger bit not cleared after access");

endmodule : tpr_pulse_template_access

/* test/tpr_pulse_template_access_tb.sv */
// Self-checking bench for the per-channel gain and indirect template access registers.
// Assumes the hdl/ files are compiled first; the bench acts as APB master and also drives every other input port.
`timescale 1ns/100ps

module tpr_pulse_template_access_tb;
  typedef struct {logic [31:0] d; logic e; bit chk;} tpr_note_t;
  logic pclk = 1'b0;
  logic presetn = 1'b0;
  logic psel = 1'b0;
  logic penable = 1'b0;
  logic pwrite = 1'b0;
  logic [9:0] paddr = 10'h000;
  logic [31:0] pwdata = 32'h0;
  logic [31:0] prdata;
  logic pready;
  logic pslverr;
  logic [31:0] template_selection = 32'h0;
  logic [2:0] shaper_channel = 3'h0;
  logic [1:0] shaper_ui = 2'h0;
  logic [3:0] shaper_position = 4'h0;
  logic [6:0] shaper_sample;
  logic [7:0] user_mode;
  logic [47:0] applied_gain;
  logic [55:0] gain_step;
  int fails = 0;
  int num_checks = 0;
  tpr_note_t notes[$];
  logic [6:0] sample_exp [8][4];
  logic [3:0] pos_tab [8][4];
  logic [5:0] gain_exp [8];
  logic [31:0] rd;

  ////////////////////////////////////////////////////////////////////////////
  // Clock of 25 ns and the design under test.
  always #12.5 pclk = ~pclk;

  tpr_pulse_template_access #(.CHANNELS(8), .ADDR_W(10)) uut (
    .pclk(pclk), .presetn(presetn), .psel(psel), .penable(penable), .pwrite(pwrite),
    .paddr(paddr), .pwdata(pwdata), .prdata(prdata), .pready(pready), .pslverr(pslverr),
    .template_selection(template_selection), .shaper_channel(shaper_channel), .shaper_ui(shaper_ui),
    .shaper_position(shaper_position), .shaper_sample(shaper_sample), .user_mode(user_mode),
    .applied_gain(applied_gain), .gain_step(gain_step)
  );

  ////////////////////////////////////////////////////////////////////////////
  // Comparison, verdict and address helpers.
  task automatic check(input logic [31:0] seen, input logic [31:0] exp);
    num_checks++;
    if (seen !== exp) begin
      fails++;
      $display("wrong value at %0t: saw %h, expected %h", $time, seen, exp);
    end
  endtask : check

  task automatic summarize();
    $display("Comparisons: %0d, mismatches: %0d", num_checks, fails);
    if (fails == 0 && num_checks > 0) begin
      $display("Testbench passed");
    end else begin
      $display("Testbench failed");
    end
    $finish;
  endtask : summarize

  // Byte address of register r (0 gain, 1 control, 2 sample value) of a channel.
  function automatic logic [9:0] radr(input int ch, input int r);
    return 10'(4 * (32 * ch + 4 + r));
  endfunction : radr

  // Expected {gain in force, step in quarter percent} for a template code.
  function automatic logic [12:0] nominal(input logic [3:0] c, input logic [5:0] g);
    case (c)
      4'h0, 4'h1: return {6'h21, 7'h0c};
      4'h9: return {6'h11, 7'h19};
      4'ha: return {6'h08, 7'h32};
      4'hb: return {6'h04, 7'h64};
      4'hc, 4'hd, 4'he, 4'hf: return {g, 7'h0c};
      default: return {6'h36, 7'h08};
    endcase
  endfunction : nominal

  ////////////////////////////////////////////////////////////////////////////
  // One APB transfer; the expected answer is noted before the request goes out.
  task automatic apb(input logic w, input logic [9:0] a, input logic [31:0] d, input logic [31:0] exp,
                     input logic err, input bit chk);
    int n;
    notes.push_back('{exp, err, chk});
    psel <= 1'b1;
    penable <= 1'b0;
    pwrite <= w;
    paddr <= a;
    pwdata <= d;
    @(posedge pclk);
    penable <= 1'b1;
    n = 0;
    do begin
      @(posedge pclk);
      n++;
    end while (pready !== 1'b1 && n < 20);
    if (n >= 20) begin
      fails++;
      summarize();
    end
    rd = prdata;
    psel <= 1'b0;
    penable <= 1'b0;
    @(posedge pclk);
  endtask : apb

  task automatic wr(input logic [9:0] a, input logic [31:0] d);
    apb(1'b1, a, d, 32'h0, 1'b0, 1'b0);
  endtask : wr

  task automatic rdchk(input logic [9:0] a, input logic [31:0] exp);
    apb(1'b0, a, 32'h0, exp, 1'b0, 1'b1);
  endtask : rdchk

  // Start one indirect access, poll the trigger until it drops, then check the control fields.
  task automatic access(input int ch, input logic dir, input int j);
    int k;
    wr(radr(ch, 1), {24'h0, 1'b1, dir, 2'(j), pos_tab[ch][j]});
    k = 0;
    do begin
      apb(1'b0, radr(ch, 1), 32'h0, 32'h0, 1'b0, 1'b0);
      k++;
    end while (rd[7] !== 1'b0 && k < 20);
    if (k >= 20) begin
      fails++;
      summarize();
    end
    rdchk(radr(ch, 1), {24'h0, 1'b0, dir, 2'(j), pos_tab[ch][j]});
  endtask : access

  ////////////////////////////////////////////////////////////////////////////
  // Watcher: every completed transfer is compared with the oldest note.
  always @(posedge pclk) begin : watch
    tpr_note_t nt;
    if (presetn === 1'b1 && pready === 1'b1) begin
      if (notes.size() == 0) begin
        fails++;
        $display("wrong value at %0t: answer without a request", $time);
      end else begin
        nt = notes.pop_front();
        check({31'h0, pslverr}, {31'h0, nt.e});
        if (nt.chk) check(prdata, nt.d);
      end
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // Main sequence.
  initial begin : main
    void'($urandom(32'h1c13));
    repeat (12) @(posedge pclk);
    presetn <= 1'b1;
    @(posedge pclk);
    // Reset values of all eight register copies.
    for (int ch = 0; ch < 8; ch++) begin
      rdchk(radr(ch, 0), 32'h21);
      rdchk(radr(ch, 1), 32'h0);
      rdchk(radr(ch, 2), 32'h0);
    end
    // Unmapped and misaligned places answer with an error and change nothing.
    apb(1'b1, 10'h01c, 32'h3f, 32'h0, 1'b1, 1'b0);
    apb(1'b0, 10'h01c, 32'h0, 32'h0, 1'b1, 1'b1);
    apb(1'b1, 10'h011, 32'h3f, 32'h0, 1'b1, 1'b0);
    rdchk(radr(0, 0), 32'h21);
    // Random gain factors per channel, upper write bits ignored.
    for (int ch = 0; ch < 8; ch++) begin
      gain_exp[ch] = 6'($urandom);
      wr(radr(ch, 0), {24'($urandom), 2'b00, gain_exp[ch]});
      rdchk(radr(ch, 0), {26'h0, gain_exp[ch]});
    end
    // Every template code on every channel, each channel offset by its number.
    for (int code = 0; code < 16; code++) begin
      for (int ch = 0; ch < 8; ch++) template_selection[4*ch +: 4] <= 4'(code + ch);
      repeat (3) @(posedge pclk);
      for (int ch = 0; ch < 8; ch++) begin
        check(32'(user_mode[ch]), 32'((code + ch) % 16 >= 12));
        check({19'h0, applied_gain[6*ch +: 6], gain_step[7*ch +: 7]},
              {19'h0, nominal(4'(code + ch), gain_exp[ch])});
      end
    end
    // Indirect writes into four unit intervals of each channel, edge samples included.
    for (int ch = 0; ch < 8; ch++) begin
      for (int j = 0; j < 4; j++) begin
        pos_tab[ch][j] = (j == 0) ? 4'h0 : (j == 3) ? 4'hf : 4'($urandom);
        sample_exp[ch][j] = 7'($urandom);
        wr(radr(ch, 2), {25'h0, sample_exp[ch][j]});
        access(ch, 1'b0, j);
      end
    end
    // Indirect reads must reload the sample value over a stale one.
    for (int ch = 0; ch < 8; ch++) begin
      for (int j = 0; j < 4; j++) begin
        wr(radr(ch, 2), {25'h0, ~sample_exp[ch][j]});
        access(ch, 1'b1, j);
        rdchk(radr(ch, 2), {25'h0, sample_exp[ch][j]});
      end
    end
    // The shaper sees the stored template only in user mode.
    template_selection <= {8{4'hc}};
    for (int ch = 0; ch < 8; ch++) begin
      for (int j = 0; j < 4; j++) begin
        shaper_channel <= 3'(ch);
        shaper_ui <= 2'(j);
        shaper_position <= pos_tab[ch][j];
        repeat (3) @(posedge pclk);
        check(32'(shaper_sample), 32'(sample_exp[ch][j]));
      end
    end
    template_selection[31:28] <= 4'h8;
    repeat (3) @(posedge pclk);
    check(32'(shaper_sample), 32'h0);
    summarize();
  end

endmodule : tpr_pulse_template_access_tb
